// ===== hw/dbms_ctrl.sv
/*
  memory map logic of the on-board dram controller: bank windows,
  split remap, bios shadow, memory cut, write protect, parity control.
  assumes i/o and memory requests are synchronous one-cycle strobes;
  ram types, interleave and upper boundary come from other registers.
*/
// Summary of operation
// R1: two 16-bit rw registers hold a24..a17 start fields of banks 0..3.
// R2: software starts each bank on a multiple of its size.
// R3: software places smaller banks above larger ones.
// R4: bank size follows ram type, 128 kb up to 8192 kb.
// R5: software enables interleaved banks with one shared start address.
// R6: interleaved span is twice bank size two-way, four times four-way.
// R7: of three equal banks, the interleaved pair sits lower.
// R8: bits 15..12 enable banks 3..0; reset disabled.
// R9: bits 11..10 pick address driver strength.
// R10: split size 256, 320 or 384 kb moves memory from 0a0000h.
// R11: split destination is a24..a19 from bits 7..2; bits 1..0 ignored.
// R12: software splits one bank only, of at least 512 kb.
// R13: software matches split size to shadow size and programs shadow.
// R14: bits 15..14 cut on-board memory from 512, 256 or 128 kb to 640 kb.
// R15: bit 13 write-protects memory at and above the upper boundary.
// R16: bit 12 blocks writes to the shadowed bios region.
// R17: bit 11 stores inverted parity on on-board writes.
// R18: bit 10 disables parity checking over the legacy port setting.
// R19: software sets a split size before enabling shadow.
// R20: rom at fe0000h through ffffffh is never shadowed.
// R21: shadow field selects none, f-segment, e and f, or f plus video.
// R22: shadow 11 maps video shadow to 0c0000h, sized by video size.
// R23: write protection withholds the column strobe on protected writes.
// R24: a bank is selected only when enabled and the address in its window.
`timescale 1ns/10ps
`default_nettype none
module dbms_ctrl
  import dbms_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // i/o port access
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  // settings held elsewhere
  input wire logic [11:0] bank_ram_type,
  input wire logic [2:0] ilv_mode,
  input wire logic [7:0] upper_boundary,
  input wire logic sys_parity_en,
  // memory cycle
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [24:0] mem_addr,
  output logic mem_ack,
  output logic dram_hit,
  output logic [3:0] bank_sel,
  output logic [24:0] dram_addr,
  output logic cas_block,
  // static controls
  output logic [1:0] addr_drive_strength,
  output logic parity_flip,
  output logic parity_check_en
);

  typedef struct packed {
    logic [15:0] start_lo;
    logic [15:0] start_hi;
    logic [15:0] split_bank;
    logic [15:0] shadow_wp;
    logic [15:0] rdata;
    logic ack;
    logic hit;
    logic [3:0] sel;
    logic [24:0] daddr;
    logic cas_blk;
    logic par_chk;
  } dbms_state_s;

  dbms_state_s s_q;
  dbms_state_s s_d;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // R4: size from ram type
  function automatic logic [8:0] bank_units(input logic [2:0] ram);
    case (dbms_ram_e'(ram))
      RAM_64K: bank_units = UNITS_64K;
      RAM_256K: bank_units = UNITS_256K;
      RAM_1M: bank_units = UNITS_1M;
      RAM_4M: bank_units = UNITS_4M;
      RAM_512K: bank_units = UNITS_512K;
      RAM_1M_CHIP: bank_units = UNITS_1M_CHIP;
      RAM_2M: bank_units = UNITS_2M;
      default: bank_units = UNITS_NONE;
    endcase
  endfunction : bank_units

  function automatic logic in_span(input logic [24:0] a, input logic [24:0] lo,
                                   input logic [24:0] hi);
    in_span = (a >= lo) && (a < hi);
  endfunction : in_span

  // ----------------------------------------
  // field views
  // ----------------------------------------
  logic [3:0] bank_on;
  logic [1:0] split_size;
  logic [5:0] split_dest;
  logic [1:0] onboard_mem_cut;
  logic upper_protect_on;
  logic rom_protect_on;
  logic [1:0] rom_shadow_select;
  logic [1:0] video_rom_size;
  logic [31:0] start_all;

  assign bank_on = s_q.split_bank[BANK_ON_LSB +: 4];
  assign split_size = s_q.split_bank[SPLIT_SIZE_LSB +: 2];
  // R11: destination a24..a19, low two bits unused
  assign split_dest = s_q.split_bank[SPLIT_DEST_LSB +: 6];
  assign onboard_mem_cut = s_q.shadow_wp[CUT_LSB +: 2];
  assign upper_protect_on = s_q.shadow_wp[UPPER_PROT_BIT];
  assign rom_protect_on = s_q.shadow_wp[ROM_PROT_BIT];
  assign rom_shadow_select = s_q.shadow_wp[SHADOW_SEL_LSB +: 2];
  assign video_rom_size = s_q.shadow_wp[VIDEO_SIZE_LSB +: 2];
  assign start_all = {s_q.start_hi, s_q.start_lo};

  // ----------------------------------------
  // address translation
  // ----------------------------------------
  logic [24:0] split_end;
  logic [24:0] shadow_base;
  logic [24:0] video_end;
  logic [24:0] xaddr;
  logic [24:0] split_off;
  logic mapped;
  logic in_video;
  logic in_sys_shadow;

  always_comb
  begin
    // R10: end of the moved block
    case (split_size)
      SPLIT_NONE: split_end = ADDR_HOLE;
      SPLIT_256K: split_end = ADDR_SEG_E;
      SPLIT_320K: split_end = ADDR_SEG_F;
      default: split_end = ADDR_1M;
    endcase
    // R21: start of system shadow
    case (rom_shadow_select)
      SHD_F64: shadow_base = ADDR_SEG_F;
      SHD_E128: shadow_base = ADDR_SEG_E;
      SHD_F_VIDEO: shadow_base = ADDR_SEG_F;
      default: shadow_base = ADDR_1M;
    endcase
    // R22: video shadow in 16 kb steps
    video_end = ADDR_VIDEO + VIDEO_STEP * (25'(video_rom_size) + 25'h1);
    in_video = (rom_shadow_select == SHD_F_VIDEO) && in_span(mem_addr, ADDR_VIDEO, video_end);
    in_sys_shadow = in_span(mem_addr, shadow_base, ADDR_1M);
    split_off = mem_addr - ADDR_HOLE;
    xaddr = mem_addr;
    mapped = 1'b1;
    // R20: top rom stays off dram
    if (in_span(mem_addr, ADDR_TOP_ROM, ADDR_TOP_END))
      mapped = 1'b0;
    // R22: video shadow lives in the e segment
    else if (in_video)
      xaddr = mem_addr + VIDEO_TO_E;
    // R11: moved block lands on a 512 kb boundary
    else if (in_span(mem_addr, ADDR_HOLE, split_end))
      xaddr = {split_dest, split_off[SPLIT_OFF_W-1:0]};
    else if (in_span(mem_addr, split_end, ADDR_1M))
      mapped = in_sys_shadow;
    // R14: cut part of base memory for bus cards
    else if (onboard_mem_cut == CUT_512K)
      mapped = !in_span(mem_addr, ADDR_512K, ADDR_HOLE);
    else if (onboard_mem_cut == CUT_256K)
      mapped = !in_span(mem_addr, ADDR_256K, ADDR_HOLE);
    else if (onboard_mem_cut == CUT_128K)
      mapped = !in_span(mem_addr, ADDR_128K, ADDR_HOLE);
  end

  // ----------------------------------------
  // bank windows
  // ----------------------------------------
  logic [3:0] way_pick;
  logic [3:0] bank_hit;
  logic [3:0] first_hit;
  logic [8:0] span [4];

  always_comb
  begin
    way_pick = 4'hf;
    // R6: span grows with interleave
    for (int i = 0; i < 4; i++)
      span[i] = bank_units(bank_ram_type[3*i +: 3]);
    case (dbms_ilv_e'(ilv_mode))
      ILV_PAIR_LO:
      begin
        span[0] = span[0] << 1;
        span[1] = span[1] << 1;
        way_pick[1:0] = {xaddr[1], !xaddr[1]};
      end
      ILV_PAIR_HI:
      begin
        span[2] = span[2] << 1;
        span[3] = span[3] << 1;
        way_pick[3:2] = {xaddr[1], !xaddr[1]};
      end
      ILV_PAIR_BOTH:
      begin
        for (int i = 0; i < 4; i++)
          span[i] = span[i] << 1;
        way_pick = {xaddr[1], !xaddr[1], xaddr[1], !xaddr[1]};
      end
      ILV_FOUR:
      begin
        for (int i = 0; i < 4; i++)
          span[i] = span[i] << 2;
        way_pick = 4'h1 << xaddr[2:1];
      end
      default:
        way_pick = 4'hf;
    endcase
  end

  // R24: enabled bank with the address inside its window
  for (genvar g = 0; g < 4; g++)
  begin : g_bank
    dbms_bank_match u_match (
      .bank_on(bank_on[g]),
      .start_blk(start_all[8*g +: 8]),
      .span_blk(span[g]),
      .addr_blk(xaddr[24:BLOCK_LSB]),
      .way_pick(way_pick[g]),
      .hit(bank_hit[g])
    );
  end

  // lowest bank wins if software overlaps windows
  assign first_hit = bank_hit & (~bank_hit + 4'h1);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic prot_write;

  always_comb
  begin
    s_d = s_q;
    // R15 R16: protected regions
    prot_write = mem_write &&
      ((rom_protect_on && (in_video || in_sys_shadow)) ||
       (upper_protect_on && (xaddr[24:BLOCK_LSB] >= upper_boundary)));
    // R1 R8 R9: register writes
    if (io_wr)
    begin
      case (io_addr)
        PORT_BANK_START_LO: s_d.start_lo = io_wdata;
        PORT_BANK_START_HI: s_d.start_hi = io_wdata;
        PORT_SPLIT_BANK_EN: s_d.split_bank = io_wdata & SPLIT_READ_MASK;
        PORT_SHADOW_WP: s_d.shadow_wp = io_wdata & SHADOW_READ_MASK;
        default: s_d.shadow_wp = s_q.shadow_wp;
      endcase
    end
    if (io_rd)
    begin
      case (io_addr)
        PORT_BANK_START_LO: s_d.rdata = s_q.start_lo;
        PORT_BANK_START_HI: s_d.rdata = s_q.start_hi;
        PORT_SPLIT_BANK_EN: s_d.rdata = s_q.split_bank;
        PORT_SHADOW_WP: s_d.rdata = s_q.shadow_wp;
        default: s_d.rdata = RST_WORD;
      endcase
    end
    s_d.ack = mem_req;
    if (mem_req)
    begin
      s_d.hit = mapped && (first_hit != 4'h0);
      s_d.sel = mapped ? first_hit : 4'h0;
      s_d.daddr = xaddr;
      // R23: column strobe withheld, row cycle still runs
      s_d.cas_blk = mapped && (first_hit != 4'h0) && prot_write;
    end
    // R18: override of the legacy parity enable
    s_d.par_chk = sys_parity_en && !s_q.shadow_wp[PARITY_OFF_BIT];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign io_rdata = s_q.rdata;
  assign mem_ack = s_q.ack;
  assign dram_hit = s_q.hit;
  assign bank_sel = s_q.sel;
  assign dram_addr = s_q.daddr;
  assign cas_block = s_q.cas_blk;
  // R9: driver strength straight from the register
  assign addr_drive_strength = s_q.split_bank[DRIVE_LSB +: 2];
  // R17: parity inversion on writes
  assign parity_flip = s_q.shadow_wp[PARITY_FLIP_BIT];
  assign parity_check_en = s_q.par_chk;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence start_lo_write;
    io_wr && !io_rd && io_addr == PORT_BANK_START_LO;
  endsequence

  sequence start_lo_read;
    io_rd && !io_wr && io_addr == PORT_BANK_START_LO;
  endsequence

  a_start_readback: assert property ( // R1
    start_lo_write ##1 start_lo_read |=> io_rdata == $past(io_wdata, 2))
    else $error("bank start register readback mismatch");

  a_sel_needs_on: assert property ( // R24
    mem_ack |-> (bank_sel & ~$past(bank_on)) == 4'h0)
    else $error("disabled bank selected");

  a_sel_onehot: assert property ( // R8
    mem_ack |-> $onehot0(bank_sel) && (dram_hit == (bank_sel != 4'h0)))
    else $error("bank select not one-hot or hit disagrees");

  a_top_rom_off: assert property ( // R20
    mem_req && mem_addr >= ADDR_TOP_ROM && mem_addr < ADDR_TOP_END |=> !dram_hit)
    else $error("top rom reached dram");

  a_split_dest: assert property ( // R11
    mem_req && split_size != SPLIT_NONE && rom_shadow_select != SHD_F_VIDEO &&
    mem_addr >= ADDR_HOLE && mem_addr < ADDR_SEG_E
    |=> dram_addr[24:19] == $past(split_dest))
    else $error("split block not sent to destination");

  a_cut_base_mem: assert property ( // R14
    mem_req && onboard_mem_cut == CUT_128K && mem_addr >= ADDR_128K && mem_addr < ADDR_HOLE
    |=> !dram_hit)
    else $error("cut base memory still mapped");

  a_upper_protect: assert property ( // R15
    mem_req && mem_write && upper_protect_on && mem_addr >= ADDR_1M &&
    mem_addr[24:BLOCK_LSB] >= upper_boundary |=> !dram_hit || cas_block)
    else $error("upper memory write not protected");

  a_cas_block_cause: assert property ( // R23
    mem_ack && cas_block |-> dram_hit && $past(mem_write))
    else $error("column strobe withheld without protected write");

  a_parity_override: assert property ( // R18
    $past(s_q.shadow_wp[PARITY_OFF_BIT]) |-> !parity_check_en)
    else $error("parity checked while disabled");

endmodule : dbms_ctrl
`default_nettype wire

// ===== hw/dbms_pkg.sv
/*
  constants for the dram bank map and shadow controller.
  assumes 16-bit i/o port data and a 25-bit (a24..a0) memory address.
*/
package dbms_pkg;

  // ----------------------------------------
  // i/o port addresses
  // ----------------------------------------
  localparam logic [15:0] PORT_BANK_START_LO = 16'h4872;
  localparam logic [15:0] PORT_BANK_START_HI = 16'h5072;
  localparam logic [15:0] PORT_SPLIT_BANK_EN = 16'h5872;
  localparam logic [15:0] PORT_SHADOW_WP = 16'h6072;

  // ----------------------------------------
  // reset values and read masks
  // ----------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] SPLIT_READ_MASK = 16'hfffc;
  localparam logic [15:0] SHADOW_READ_MASK = 16'hffbf;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BANK_ON_LSB = 12;
  localparam int DRIVE_LSB = 10;
  localparam int SPLIT_SIZE_LSB = 8;
  localparam int SPLIT_DEST_LSB = 2;
  localparam int CUT_LSB = 14;
  localparam int UPPER_PROT_BIT = 13;
  localparam int ROM_PROT_BIT = 12;
  localparam int PARITY_FLIP_BIT = 11;
  localparam int PARITY_OFF_BIT = 10;
  localparam int SHADOW_SEL_LSB = 8;
  localparam int VIDEO_SIZE_LSB = 4;
  localparam int BLOCK_LSB = 17;
  localparam int SPLIT_OFF_W = 19;

  // ----------------------------------------
  // address map of the low megabyte and the top rom
  // ----------------------------------------
  localparam logic [24:0] ADDR_128K = 25'h0020000;
  localparam logic [24:0] ADDR_256K = 25'h0040000;
  localparam logic [24:0] ADDR_512K = 25'h0080000;
  localparam logic [24:0] ADDR_HOLE = 25'h00a0000;
  localparam logic [24:0] ADDR_VIDEO = 25'h00c0000;
  localparam logic [24:0] ADDR_SEG_E = 25'h00e0000;
  localparam logic [24:0] ADDR_SEG_F = 25'h00f0000;
  localparam logic [24:0] ADDR_1M = 25'h0100000;
  localparam logic [24:0] ADDR_TOP_ROM = 25'h0fe0000;
  localparam logic [24:0] ADDR_TOP_END = 25'h1000000;
  localparam logic [24:0] VIDEO_STEP = 25'h0004000;
  localparam logic [24:0] VIDEO_TO_E = 25'h0020000;

  // ----------------------------------------
  // bank sizes in 128 kbyte blocks
  // ----------------------------------------
  localparam logic [8:0] UNITS_64K = 9'h001;
  localparam logic [8:0] UNITS_256K = 9'h004;
  localparam logic [8:0] UNITS_1M = 9'h010;
  localparam logic [8:0] UNITS_4M = 9'h040;
  localparam logic [8:0] UNITS_512K = 9'h008;
  localparam logic [8:0] UNITS_1M_CHIP = 9'h010;
  localparam logic [8:0] UNITS_2M = 9'h020;
  localparam logic [8:0] UNITS_NONE = 9'h000;

  typedef enum logic [2:0] {
    RAM_64K, RAM_256K, RAM_1M, RAM_4M, RAM_512K, RAM_1M_CHIP, RAM_2M, RAM_RSVD
  } dbms_ram_e;

  typedef enum logic [2:0] {
    ILV_NONE, ILV_PAIR_LO, ILV_PAIR_HI, ILV_PAIR_BOTH, ILV_FOUR, ILV_RSVD5, ILV_RSVD6, ILV_RSVD7
  } dbms_ilv_e;

  localparam logic [1:0] SPLIT_NONE = 2'h0;
  localparam logic [1:0] SPLIT_256K = 2'h1;
  localparam logic [1:0] SPLIT_320K = 2'h2;
  localparam logic [1:0] SHD_NONE = 2'h0;
  localparam logic [1:0] SHD_F64 = 2'h1;
  localparam logic [1:0] SHD_E128 = 2'h2;
  localparam logic [1:0] SHD_F_VIDEO = 2'h3;
  localparam logic [1:0] CUT_512K = 2'h1;
  localparam logic [1:0] CUT_256K = 2'h2;
  localparam logic [1:0] CUT_128K = 2'h3;

endpackage : dbms_pkg

// ===== hw/dbms_bank_match.sv
/*
  window compare for one dram bank.
  assumes start and span are given in 128 kbyte blocks.
*/
`timescale 1ns/10ps
`default_nettype none
module dbms_bank_match
  import dbms_pkg::*;
(
  // bank setup
  input wire logic bank_on,
  input wire logic [7:0] start_blk,
  input wire logic [8:0] span_blk,
  // cycle
  input wire logic [7:0] addr_blk,
  input wire logic way_pick,
  // result
  output logic hit
);
  logic [8:0] end_blk;

  // 9 bits hold start plus a four-way span without wrap
  assign end_blk = {1'b0, start_blk} + span_blk;
  assign hit = bank_on && way_pick && (addr_blk >= start_blk) && ({1'b0, addr_blk} < end_blk);
endmodule : dbms_bank_match
`default_nettype wire

// ===== tb/dbms_cpu_model.sv
/*
  processor side: issues one-cycle memory requests to the controller.
  assumes the controller samples a request on the edge it is raised for.
*/
`timescale 1ns/10ps
`default_nettype none
module dbms_cpu_model
  import dbms_pkg::*;
(
  // clock
  input wire logic core_clk,
  // memory cycle
  output logic mem_req,
  output logic mem_write,
  output logic [24:0] mem_addr
);
  initial
  begin
    mem_req = 1'b0;
    mem_write = 1'b0;
    mem_addr = 25'h0000000;
  end
  // request stands one edge; released lines then change so stale values never match
  task automatic cycle(input logic [24:0] a, input logic wr);
    @(posedge core_clk);
    #1;
    mem_req = 1'b1;
    mem_write = wr;
    mem_addr = a;
    @(posedge core_clk);
    #1;
    mem_req = 1'b0;
    mem_write = ~wr;
    mem_addr = ~a;
  endtask : cycle
endmodule : dbms_cpu_model
`default_nettype wire

// ===== tb/tb_top.sv
/*
  self-checking bench for the dram bank map controller.
  assumes a 50 ns core clock and the processor model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import dbms_pkg::*;
();
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [15:0] io_wdata = 16'h0000;
  logic [15:0] io_rdata;
  logic [11:0] bank_ram_type = 12'h000;
  logic [2:0] ilv_mode = 3'h0;
  logic [7:0] upper_boundary = 8'h00;
  logic sys_parity_en = 1'b0;
  logic mem_req, mem_write, mem_ack, dram_hit, cas_block;
  logic [24:0] mem_addr, dram_addr;
  logic [3:0] bank_sel;
  logic [1:0] addr_drive_strength;
  logic parity_flip, parity_check_en;
  int miscompares = 0;
  int checked = 0;

  always #25 core_clk = ~core_clk;

  dbms_ctrl u_dbms_ctrl (.core_clk(core_clk), .arst_n(arst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .bank_ram_type(bank_ram_type), .ilv_mode(ilv_mode), .upper_boundary(upper_boundary),
    .sys_parity_en(sys_parity_en), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .dram_hit(dram_hit), .bank_sel(bank_sel),
    .dram_addr(dram_addr), .cas_block(cas_block), .addr_drive_strength(addr_drive_strength),
    .parity_flip(parity_flip), .parity_check_en(parity_check_en));
  dbms_cpu_model u_dbms_cpu_model (.core_clk(core_clk), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr));

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chk_v(input string what, input logic [24:0] exp, input logic [24:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_v
  task automatic chk_b(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_b
  task automatic io_put(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(posedge core_clk);
    #1;
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask : io_put
  task automatic io_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    #1;
    io_rd = 1'b1;
    io_addr = a;
    @(posedge core_clk);
    #1;
    io_rd = 1'b0;
    chk_v("io_rdata", 25'(exp), 25'(io_rdata));
  endtask : io_chk
  task automatic mem_chk(input logic [24:0] a, input logic wr, input logic hit);
    u_dbms_cpu_model.cycle(a, wr);
    chk_b("mem_ack", 1'b1, mem_ack);
    chk_b("dram_hit", hit, dram_hit);
  endtask : mem_chk
  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    io_chk(PORT_SPLIT_BANK_EN, 16'h0000);
    io_chk(PORT_SHADOW_WP, 16'h0000);
    // write then read on the next edge, no idle cycle between
    @(posedge core_clk);
    #1;
    io_wr = 1'b1;
    io_addr = PORT_BANK_START_LO;
    io_wdata = 16'h1234;
    @(posedge core_clk);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b1;
    @(posedge core_clk);
    #1;
    io_rd = 1'b0;
    chk_v("io_rdata", 25'h0001234, 25'(io_rdata));
    io_put(PORT_BANK_START_LO, 16'ha5c3);
    io_put(PORT_BANK_START_HI, 16'h3c5a);
    io_put(PORT_SHADOW_WP, 16'hffff);
    io_put(16'h7872, 16'hffff);
    io_chk(PORT_BANK_START_LO, 16'ha5c3);
    io_chk(PORT_BANK_START_HI, 16'h3c5a);
    io_chk(PORT_SHADOW_WP, 16'hffbf);
    io_chk(16'h7872, 16'h0000);
    for (int d = 0; d < 4; d++)
    begin
      io_put(PORT_SPLIT_BANK_EN, 16'(d << 10) | 16'h0003);
      chk_v("drive", 25'(d), 25'(addr_drive_strength));
      io_chk(PORT_SPLIT_BANK_EN, 16'(d << 10));
    end
    io_put(PORT_BANK_START_LO, 16'h0000);
    io_put(PORT_BANK_START_HI, 16'h0000);
    io_put(PORT_SHADOW_WP, 16'h0000);
  endtask : t_regs
  task automatic t_sizes();
    int kb [7] = '{128, 512, 2048, 8192, 1024, 2048, 4096};
    io_put(PORT_SPLIT_BANK_EN, 16'h0000);
    mem_chk(25'h0000000, 1'b0, 1'b0);
    io_put(PORT_SPLIT_BANK_EN, 16'h1000);
    // window above 16 mb keeps every bank top clear of the unmapped 640k..1m hole
    io_put(PORT_BANK_START_LO, 16'h0080);
    for (int t = 0; t < 7; t++)
    begin
      bank_ram_type = 12'(t);
      mem_chk(25'h1000000 + 25'(kb[t] * 1024 - 2), 1'b0, 1'b1);
      chk_v("bank_sel", 25'h1, 25'(bank_sel));
      mem_chk(25'h1000000 + 25'(kb[t] * 1024), 1'b0, 1'b0);
    end
    io_put(PORT_BANK_START_LO, 16'h0000);
  endtask : t_sizes
  task automatic t_ilv();
    bank_ram_type = 12'h024;
    ilv_mode = 3'h1;
    io_put(PORT_SPLIT_BANK_EN, 16'h3000);
    mem_chk(25'h01ffffe, 1'b0, 1'b1);
    chk_v("bank_sel", 25'h2, 25'(bank_sel));
    mem_chk(25'h0200000, 1'b0, 1'b0);
    bank_ram_type = 12'h249;
    ilv_mode = 3'h4;
    io_put(PORT_SPLIT_BANK_EN, 16'hf000);
    mem_chk(25'h01ffffe, 1'b0, 1'b1);
    chk_v("bank_sel", 25'h8, 25'(bank_sel));
    mem_chk(25'h0200000, 1'b0, 1'b0);
    ilv_mode = 3'h2;
    io_put(PORT_BANK_START_LO, 16'h0800);
    io_put(PORT_SPLIT_BANK_EN, 16'he000);
    mem_chk(25'h007fffe, 1'b0, 1'b1);
    chk_v("bank_sel", 25'h8, 25'(bank_sel));
    mem_chk(25'h0100000, 1'b0, 1'b1);
    chk_v("bank_sel", 25'h2, 25'(bank_sel));
    mem_chk(25'h0180000, 1'b0, 1'b0);
    ilv_mode = 3'h3;
    mem_chk(25'h007fffc, 1'b0, 1'b1);
    chk_v("bank_sel", 25'h4, 25'(bank_sel));
    io_put(PORT_BANK_START_LO, 16'h0000);
    ilv_mode = 3'h0;
  endtask : t_ilv
  task automatic t_top();
    bank_ram_type = 12'h0c0;
    upper_boundary = 8'h60;
    io_put(PORT_BANK_START_HI, 16'h0040);
    io_put(PORT_SPLIT_BANK_EN, 16'h4000);
    io_put(PORT_SHADOW_WP, 16'h2000);
    mem_chk(25'h07ffffe, 1'b0, 1'b0);
    mem_chk(25'h0800000, 1'b0, 1'b1);
    chk_v("bank_sel", 25'h4, 25'(bank_sel));
    mem_chk(25'h0fe0000, 1'b0, 1'b0);
    mem_chk(25'h0bffffe, 1'b1, 1'b1);
    chk_b("cas_block", 1'b0, cas_block);
    mem_chk(25'h0c00000, 1'b1, 1'b1);
    chk_b("cas_block", 1'b1, cas_block);
    mem_chk(25'h0c00000, 1'b0, 1'b1);
    chk_b("cas_block", 1'b0, cas_block);
    io_put(PORT_SHADOW_WP, 16'h0000);
    mem_chk(25'h0c00000, 1'b1, 1'b1);
    chk_b("cas_block", 1'b0, cas_block);
    io_put(PORT_BANK_START_HI, 16'h0000);
  endtask : t_top
  task automatic t_split();
    logic [24:0] lim [3] = '{25'h00dfffe, 25'h00efffe, 25'h00ffffe};
    bank_ram_type = 12'h002;
    io_put(PORT_SPLIT_BANK_EN, 16'h1008);
    mem_chk(ADDR_HOLE, 1'b0, 1'b0);
    for (int s = 1; s < 4; s++)
    begin
      io_put(PORT_SPLIT_BANK_EN, 16'h100b | 16'(s << 8));
      mem_chk(ADDR_HOLE, 1'b0, 1'b1);
      chk_v("dram_addr", ADDR_1M, dram_addr);
      mem_chk(lim[s - 1], 1'b0, 1'b1);
      if (s < 3)
        mem_chk(lim[s - 1] + 25'h2, 1'b0, 1'b0);
    end
  endtask : t_split
  task automatic t_cut();
    logic [24:0] cut_at [3] = '{ADDR_512K, ADDR_256K, ADDR_128K};
    io_put(PORT_SPLIT_BANK_EN, 16'h1000);
    mem_chk(25'h009fffe, 1'b0, 1'b1);
    for (int c = 1; c < 4; c++)
    begin
      io_put(PORT_SHADOW_WP, 16'(c << 14));
      mem_chk(cut_at[c - 1], 1'b0, 1'b0);
      mem_chk(cut_at[c - 1] - 25'h2, 1'b0, 1'b1);
      mem_chk(25'h009fffe, 1'b0, 1'b0);
    end
  endtask : t_cut
  task automatic t_shadow();
    io_put(PORT_SPLIT_BANK_EN, 16'h1208);
    io_put(PORT_SHADOW_WP, 16'h1100);
    mem_chk(ADDR_SEG_F, 1'b0, 1'b1);
    mem_chk(ADDR_SEG_F, 1'b1, 1'b1);
    chk_b("cas_block", 1'b1, cas_block);
    mem_chk(ADDR_HOLE, 1'b1, 1'b1);
    chk_b("cas_block", 1'b0, cas_block);
    io_put(PORT_SPLIT_BANK_EN, 16'h1108);
    io_put(PORT_SHADOW_WP, 16'h0200);
    mem_chk(ADDR_SEG_E, 1'b1, 1'b1);
    chk_b("cas_block", 1'b0, cas_block);
    io_put(PORT_SHADOW_WP, 16'h0300);
    mem_chk(ADDR_VIDEO, 1'b0, 1'b1);
    chk_v("dram_addr", ADDR_SEG_E, dram_addr);
    io_put(PORT_SHADOW_WP, 16'h0330);
    mem_chk(25'h00cfffe, 1'b0, 1'b1);
    chk_v("dram_addr", 25'h00efffe, dram_addr);
    mem_chk(ADDR_SEG_F, 1'b0, 1'b1);
  endtask : t_shadow
  task automatic t_parity();
    sys_parity_en = 1'b1;
    io_put(PORT_SHADOW_WP, 16'h0800);
    repeat (2) @(posedge core_clk);
    #1;
    chk_b("parity_flip", 1'b1, parity_flip);
    chk_b("parity_check_en", 1'b1, parity_check_en);
    io_put(PORT_SHADOW_WP, 16'h0400);
    repeat (2) @(posedge core_clk);
    #1;
    chk_b("parity_flip", 1'b0, parity_flip);
    chk_b("parity_check_en", 1'b0, parity_check_en);
  endtask : t_parity

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    t_regs();
    t_sizes();
    t_ilv();
    t_top();
    t_split();
    t_cut();
    t_shadow();
    t_parity();
    finish_test();
  end
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
